// *** sit_channel.v ***
// one scheduled interrupt channel: interval, internal count, enable
// assumes a shared 0.1 ms tick pulse and one-cycle commands
`timescale 1ns/10ps
`include "sit_defs.vh"
module sit_channel
(
	// clock and reset
	input wire clock_i,
	input wire resetn_i,
	// time base
	input wire tick_i,
	input wire [3:0] unit_i,
	// commands
	input wire start_i,
	input wire reset_start_i,
	input wire prohibit_i,
	input wire [`SIT_W-1:0] interval_i,
	// state
	output reg [`SIT_W-1:0] interval_o,
	output reg [`SIT_W-1:0] present_count_o,
	output reg enabled_o,
	output reg irq_o
);
	reg [6:0] prescale;
	wire [6:0] div_top;
	wire unit_tick;
	wire [`SIT_W-1:0] next_count;

	// prescale 0.1 ms ticks into the selected unit
	assign div_top = (unit_i == `SIT_UNIT_10MS) ? (`SIT_DIV_10MS - 7'h01) :
		(unit_i == `SIT_UNIT_1MS) ? {3'h0, `SIT_DIV_1MS} - 7'h01 : 7'h00;
	assign unit_tick = tick_i && (prescale == div_top);
	assign next_count = present_count_o + {{(`SIT_W-1){1'b0}}, 1'b1};

	// channel state
	always @(posedge clock_i)
	begin
		irq_o <= 1'b0;
		if (!resetn_i)
		begin
			prescale <= 7'h00;
			interval_o <= {`SIT_W{1'b0}};
			present_count_o <= {`SIT_W{1'b0}};
			enabled_o <= 1'b0;
		end
		else if (prohibit_i)
			enabled_o <= 1'b0;
		else if (start_i || reset_start_i)
		begin
			interval_o <= interval_i;
			enabled_o <= 1'b1;
			if (reset_start_i)
			begin
				present_count_o <= {`SIT_W{1'b0}};
				prescale <= 7'h00;
			end
			// normal start leaves the count running
		end
		else if (enabled_o && tick_i)
		begin
			prescale <= unit_tick ? 7'h00 : prescale + 7'h01;
			if (unit_tick)
			begin
				if (next_count >= interval_o)
				begin
					present_count_o <= {`SIT_W{1'b0}};
					irq_o <= 1'b1;
				end
				else
					present_count_o <= next_count;
			end
		end
	end
endmodule

// *** sit_defs.vh ***
// constants for the two-channel scheduled interrupt timer
// assumes a 250 MHz core clock and a program side issuing one-cycle commands
`ifndef SIT_DEFS_VH
`define SIT_DEFS_VH
`define SIT_UNIT_10MS 4'h0
`define SIT_UNIT_1MS 4'h1
`define SIT_UNIT_100US 4'h2
`define SIT_NUM_NORM0 5'h04
`define SIT_NUM_NORM1 5'h05
`define SIT_NUM_RST0 5'h0e
`define SIT_NUM_RST1 5'h0f
`define SIT_CLK_MHZ 250
`define SIT_TICK_US 100
`define SIT_TICK_CYC (`SIT_CLK_MHZ * `SIT_TICK_US)
`define SIT_TICK_LAST 15'h61a7
`define SIT_DIV_1MS 4'ha
`define SIT_DIV_10MS 7'h64
`define SIT_MAX_100US 14'h270f
`define SIT_MIN_FAST 14'h0002
`define SIT_MIN_COMPACT 14'h0005
`define SIT_MIN_OTHER 14'h0001
`define SIT_W 14
`endif

// *** sit_timer.v ***
// two-channel scheduled interrupt timer with start, reset start, prohibit and readback
// assumes commands are one-cycle pulses from the instruction sequencer
`timescale 1ns/10ps
`include "sit_defs.vh"
module sit_timer
(
	// clock and reset
	input wire clock_i,
	input wire resetn_i,
	// configuration
	input wire [3:0] unit_sel_i,
	input wire compact_i,
	input wire run_start_i,
	// mask set command
	input wire mask_set_i,
	input wire mask_prohibit_i,
	input wire [4:0] mask_num_i,
	input wire [`SIT_W-1:0] mask_interval_i,
	// mask read command
	input wire mask_read_i,
	input wire [4:0] read_num_i,
	// results
	output reg cmd_error_o,
	output reg read_valid_o,
	output reg [`SIT_W-1:0] read_data_o,
	output wire [1:0] irq_o
);
	reg [3:0] unit;
	reg [14:0] tick_cnt;
	wire tick;
	wire [1:0] is_norm;
	wire [1:0] is_rst;
	wire [`SIT_W-1:0] min_iv;
	wire iv_ok;
	wire [`SIT_W-1:0] iv_q [0:1];
	wire [`SIT_W-1:0] pc_q [0:1];

	// unit latched when operation starts; unknown codes fall to 10 ms
	always @(posedge clock_i)
	begin
		if (!resetn_i)
			unit <= `SIT_UNIT_10MS;
		else if (run_start_i)
			unit <= (unit_sel_i == `SIT_UNIT_1MS || (unit_sel_i == `SIT_UNIT_100US)) ?
				unit_sel_i : `SIT_UNIT_10MS;
	end

	// 0.1 ms base tick from the core clock
	always @(posedge clock_i)
	begin
		if (!resetn_i || tick)
			tick_cnt <= 15'h0000;
		else
			tick_cnt <= tick_cnt + 15'h0001;
	end
	assign tick = (tick_cnt == `SIT_TICK_LAST); // last cycle of each 0.1 ms period

	// command decode
	assign is_norm[0] = mask_num_i == `SIT_NUM_NORM0;
	assign is_norm[1] = mask_num_i == `SIT_NUM_NORM1;
	assign is_rst[0] = compact_i && (mask_num_i == `SIT_NUM_RST0);
	assign is_rst[1] = compact_i && (mask_num_i == `SIT_NUM_RST1);

	// interval range check; 0.1 ms minimum depends on the variant
	assign min_iv = (unit != `SIT_UNIT_100US) ? `SIT_MIN_OTHER :
		compact_i ? `SIT_MIN_COMPACT : `SIT_MIN_FAST;
	assign iv_ok = mask_prohibit_i || ((mask_interval_i >= min_iv) &&
		(mask_interval_i <= `SIT_MAX_100US));

	// two channels
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gen_ch
			sit_channel u_ch
			(
				.clock_i(clock_i),
				.resetn_i(resetn_i),
				.tick_i(tick),
				.unit_i(unit),
				.start_i(mask_set_i && !mask_prohibit_i && iv_ok && is_norm[g]),
				.reset_start_i(mask_set_i && !mask_prohibit_i && iv_ok && is_rst[g]),
				.prohibit_i(mask_set_i && mask_prohibit_i && (is_norm[g] || is_rst[g])),
				.interval_i(mask_interval_i),
				.interval_o(iv_q[g]),
				.present_count_o(pc_q[g]),
				.enabled_o(),
				.irq_o(irq_o[g])
			);
		end
	endgenerate

	// readback and error flag
	always @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			read_valid_o <= 1'b0;
			read_data_o <= {`SIT_W{1'b0}};
			cmd_error_o <= 1'b0;
		end
		else
		begin
			read_valid_o <= 1'b0;
			cmd_error_o <= mask_set_i && !(iv_ok && (is_norm != 2'b00 || is_rst != 2'b00));
			if (mask_read_i)
			begin
				read_valid_o <= 1'b1;
				case (read_num_i)
					`SIT_NUM_NORM0: read_data_o <= iv_q[0];
					`SIT_NUM_NORM1: read_data_o <= iv_q[1];
					`SIT_NUM_RST0: read_data_o <= compact_i ? pc_q[0] : {`SIT_W{1'b0}};
					`SIT_NUM_RST1: read_data_o <= compact_i ? pc_q[1] : {`SIT_W{1'b0}};
					default:
					begin
						read_data_o <= {`SIT_W{1'b0}};
						cmd_error_o <= 1'b1;
					end
				endcase
				if (!compact_i && (read_num_i == `SIT_NUM_RST0 || read_num_i == `SIT_NUM_RST1))
					cmd_error_o <= 1'b1;
			end
		end
	end
endmodule

// *** sit_timer_props.sv ***
// assertions on the timer command, readback and interrupt ports
// bound into sit_timer, sees only its ports
`timescale 1ns/10ps
module sit_timer_props
(
	// clock, reset and commands
	input wire clock_i,
	input wire resetn_i,
	input wire compact_i,
	input wire mask_set_i,
	input wire mask_prohibit_i,
	input wire [4:0] mask_num_i,
	input wire [13:0] mask_interval_i,
	input wire mask_read_i,
	input wire [4:0] read_num_i,
	// results
	input wire cmd_error_o,
	input wire read_valid_o,
	input wire [13:0] read_data_o,
	input wire [1:0] irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// a set command that is not a prohibit
	wire set_ok = mask_set_i && !mask_prohibit_i;
	// channel 0 stays silent for eight cycles
	sequence s_quiet0;
		!irq_o[0] [*8];
	endsequence
	a_read_answer: assert property (read_valid_o == $past(mask_read_i)) else $error("read answer");
	a_bad_number: assert property (set_ok && !(mask_num_i inside {4, 5, 14, 15}) |=> cmd_error_o)
		else $error("bad number taken");
	a_high_interval: assert property (set_ok && mask_interval_i > 9999 |=> cmd_error_o) else $error("high");
	a_zero_interval: assert property (set_ok && mask_interval_i == 0 |=> cmd_error_o) else $error("zero");
	a_fast_reset: assert property (set_ok && !compact_i && mask_num_i > 13 |=> cmd_error_o) else $error("rst");
	a_fast_count: assert property (mask_read_i && !compact_i && read_num_i > 13 |=> read_data_o == 0)
		else $error("count read");
	a_irq_pulse: assert property (irq_o[1] |=> !irq_o[1]) else $error("irq pulse");
	a_prohibit_quiet: assert property (mask_set_i && mask_prohibit_i && mask_num_i == 4 |=> s_quiet0)
		else $error("irq after prohibit");
endmodule
bind sit_timer sit_timer_props i_props(.*);

// *** sit_timer_tb.sv ***
// self-checking bench: command model, readback and interrupt timing
// assumes sit_timer and its checker are compiled alongside
`timescale 1ns/10ps
`include "sit_defs.vh"
module sit_timer_tb;
	reg clock_i = 0, resetn_i = 0, compact_i = 0, run_start_i = 0, mask_set_i = 0, mask_prohibit_i = 0, mask_read_i = 0;
	reg [3:0] unit_sel_i = 0;
	reg [4:0] mask_num_i = 0, read_num_i = 0, n;
	reg [13:0] mask_interval_i = 0;
	wire cmd_error_o, read_valid_o;
	wire [13:0] read_data_o;
	wire [1:0] irq_o;
	integer n_fail = 0, checked = 0, i, c, u, q = 0;
	reg watch0 = 0;
	integer ivm [0:1];
	reg [31:0] lf = 32'h99a3;
	sit_timer i_sit_timer(.*);
	// clock and watchdog
	initial forever #2 clock_i = !clock_i;
	initial
	begin
		#280000 n_fail = n_fail + 1;
		complete_run;
	end
	// collects channel 0 interrupts while it is meant to be prohibited
	always @(negedge clock_i)
		if (watch0)
			q = q | irq_o[0];
	function [31:0] nx(input [31:0] v);
		nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// refusal model: number, variant and unit-dependent interval range
	function bad(input [4:0] n, input [13:0] v, input integer u);
		bad = !(n == 4 || n == 5 || (compact_i && n > 13 && n < 16)) || v > 9999 || v < (u != 2 ? 1 : compact_i ? 5 : 2);
	endfunction
	task chk(input [13:0] s, input [13:0] e);
	begin
		checked = checked + 1;
		if (s !== e)
		begin
			n_fail = n_fail + 1;
			$display("Error %0t: seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task complete_run;
	begin
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	// one-cycle set or read command, released at the next falling edge
	task go(input r, input p, input [4:0] num, input [13:0] v);
	begin
		@(negedge clock_i);
		mask_read_i = r;
		mask_set_i = !r;
		mask_prohibit_i = p;
		mask_num_i = num;
		read_num_i = num;
		mask_interval_i = v;
		@(negedge clock_i);
		mask_read_i = 0;
		mask_set_i = 0;
	end
	endtask
	// main sequence
	initial
	begin
		ivm[0] = 0;
		ivm[1] = 0;
		repeat (3) @(posedge clock_i);
		@(negedge clock_i) resetn_i = 1;
		chk(read_data_o | irq_o | cmd_error_o | read_valid_o, 0);
		for (i = 0; i < 16; i = i + 1)
		begin
			lf = nx(lf);
			u = (i + 2) % 4;
			@(negedge clock_i) run_start_i = 1;
			unit_sel_i = u;
			@(negedge clock_i) run_start_i = 0;
			compact_i = lf[0];
			n = lf[3] ? 6 : (lf[1] ? 14 : 4) + lf[2];
			c = i < 8 ? i : 9992 + i;
			go(0, 0, n, c);
			chk(cmd_error_o, bad(n, c, u));
			if (!bad(n, c, u)) ivm[n[0]] = c;
			go(1, 0, 4 + n[0], 0);
			chk(read_data_o, ivm[n[0]]);
		end
		compact_i = 0;
		go(1, 0, 14, 0);
		chk(read_data_o, 0);
		@(negedge clock_i) run_start_i = 1;
		unit_sel_i = `SIT_UNIT_100US;
		@(negedge clock_i) run_start_i = 0;
		compact_i = 1;
		go(0, 0, 14, 5);
		chk(cmd_error_o, 0);
		go(0, 0, 15, 5);
		chk(cmd_error_o, 0);
		compact_i = 0;
		go(0, 0, 4, 2);
		chk(cmd_error_o, 0);
		go(0, 1, 4, 50);
		chk(cmd_error_o, 0);
		watch0 = 1;
		compact_i = 1;
		// wait for the first 0.1 ms tick of channel 1
		for (c = 0; c == 0 || (read_data_o == 0 && c < 13000); c = c + 1)
			go(1, 0, 15, 0);
		chk(read_data_o, 1);
		compact_i = 0;
		go(0, 0, 5, 2);
		chk(cmd_error_o, 0);
		compact_i = 1;
		go(1, 0, 15, 0);
		chk(read_data_o, 1);
		for (c = 0; !irq_o[1] && c < 30000; c = c + 1) @(negedge clock_i);
		chk(c > 24000 && c < 25010, 1);
		go(1, 0, 15, 0);
		chk(read_data_o, 0);
		go(1, 0, 5, 0);
		chk(read_data_o, 2);
		watch0 = 0;
		chk(q, 0);
		go(0, 1, 5, 50);
		chk(cmd_error_o, 0);
		// mid-run reset clears outputs and intervals
		@(negedge clock_i) resetn_i = 0;
		repeat (3) @(negedge clock_i);
		resetn_i = 1;
		chk(read_data_o | irq_o | cmd_error_o | read_valid_o, 0);
		go(1, 0, 5, 0);
		chk(read_data_o, 0);
		complete_run;
	end
endmodule
